// *** mcrb_pkg.sv ***
// mcrb_pkg: offsets, field layouts, reset values and constants of the
// miscellaneous control register bank.
// assumes: byte addresses on a 32-bit avalon-mm slave, one word per register.
package mcrb_pkg;
   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [11:0] OFS_ENGINE_RESET = 12'h020;
   localparam logic [11:0] OFS_INT_MASK     = 12'h0b0;
   localparam logic [11:0] OFS_PWM_HZ       = 12'h0d0;
   localparam logic [11:0] OFS_PWM_DUTY     = 12'h0d4;
   localparam logic [11:0] OFS_MACRO_ZERO   = 12'h0d8;
   localparam logic [11:0] OFS_MACRO_ONE    = 12'h0dc;
   localparam logic [11:0] OFS_FREE_BYTES   = 12'h574;
   localparam logic [11:0] OFS_BULK_WRITE   = 12'h578;
   localparam logic [11:0] OFS_INT_STATUS   = 12'h580;
   // ****************************************************************
   // field positions and widths
   // ****************************************************************
   localparam int ENG_COPRO_BIT = 0;  // coprocessor engine reset
   localparam int ENG_TOUCH_BIT = 1;  // touch engine reset
   localparam int ENG_AUDIO_BIT = 2;  // audio engine reset
   localparam int ENG_W         = 3;
   localparam int FREE_W        = 12;
   localparam int HZ_W          = 14;
   localparam int DUTY_W        = 8;
   localparam int INT_W         = 8;
   // ****************************************************************
   // reset values and limits
   // ****************************************************************
   localparam logic [ENG_W-1:0]  RST_ENGINE = 3'h0;
   localparam logic [FREE_W-1:0] RST_FREE   = 12'hffc;
   localparam logic [FREE_W-1:0] WORD_BYTES = 12'h004;
   localparam logic [HZ_W-1:0]   RST_HZ     = 14'h00fa;
   localparam logic [HZ_W-1:0]   HZ_MIN     = 14'h00fa;
   localparam logic [HZ_W-1:0]   HZ_MAX     = 14'h2710;
   localparam logic [DUTY_W-1:0] RST_DUTY   = 8'h80;
   localparam logic [INT_W-1:0]  RST_MASK   = 8'hff;
   localparam logic [31:0]       RST_MACRO  = 32'h0000_0000;
   // ****************************************************************
   // timing and encodings
   // ****************************************************************
   localparam longint CLK_HZ      = 125000000;
   localparam longint PHASE_SCALE = (64'h1_0000_0000) / CLK_HZ;
   localparam logic [7:0] MACRO_OPC = 8'h25; // display list macro opcode
endpackage : mcrb_pkg

// *** mcrb_cfg_if.sv ***
// mcrb_cfg_if: settings that the register bank hands to its helpers.
// assumes: one clock domain, driven only by the register bank.
`timescale 1ns/10ps
interface mcrb_cfg_if;
   logic [13:0] pwm_hz;     // backlight frequency in hz
   logic [7:0]  pwm_duty;   // backlight duty, 0..128
   logic [31:0] macro_zero; // substitute for macro with parameter 0
   logic [31:0] macro_one;  // substitute for macro with parameter 1
   modport src        (output pwm_hz, pwm_duty, macro_zero, macro_one);
   modport pwm_sink   (input pwm_hz, pwm_duty);
   modport macro_sink (input macro_zero, macro_one);
endinterface : mcrb_cfg_if

// *** mcrb_pwm.sv ***
// mcrb_pwm: backlight pwm from a frequency in hz and a 0..128 duty.
// assumes: settings come from the register bank on the same clock.
`timescale 1ns/10ps
module mcrb_pwm #(
   parameter int ACC_W = 32  // phase accumulator width
) (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_i,
   // settings
   mcrb_cfg_if.pwm_sink cfg,
   // output
   output logic      backlight_o
);
   // ****************************************************************
   // phase accumulator
   // ****************************************************************
   if (ACC_W != 32) begin : g_chk
      $error("mcrb_pwm: ACC_W must be 32 to match the phase scale");
   end
   logic [ACC_W-1:0]  phase_ff;  // one turn is one pwm period
   logic [13:0]       hz_clamp;  // frequency held inside its range
   logic [ACC_W-1:0]  step;      // phase advance per clock
   logic              backlight_ff;
   // out-of-range frequencies are clamped rather than trusted
   always_comb begin
      hz_clamp = cfg.pwm_hz;
      if (cfg.pwm_hz < mcrb_pkg::HZ_MIN) begin
         hz_clamp = mcrb_pkg::HZ_MIN;
      end else if (cfg.pwm_hz > mcrb_pkg::HZ_MAX) begin
         hz_clamp = mcrb_pkg::HZ_MAX;
      end
      // integer scale: about 1 percent slow, traded for no divider
      step = ACC_W'(hz_clamp * mcrb_pkg::PHASE_SCALE); // R11
   end
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         phase_ff <= '0;
      end else begin
         phase_ff <= phase_ff + step;
      end
   end
   // ****************************************************************
   // duty compare: top 7 phase bits run 0..127
   // ****************************************************************
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         backlight_ff <= 1'b0;
      end else begin
         // 0 never on, 128 and above always on
         backlight_ff <= ({1'b0, phase_ff[ACC_W-1 -: 7]} < cfg.pwm_duty); // R10
      end
   end
   assign backlight_o = backlight_ff;
endmodule : mcrb_pwm

// *** mcrb_macro.sv ***
// mcrb_macro: replaces display list macro commands by a register value.
// assumes: one display list word per valid cycle, no back-pressure.
`timescale 1ns/10ps
module mcrb_macro (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // macro values
   mcrb_cfg_if.macro_sink   cfg,
   // incoming display list word
   input  wire logic        dl_valid_i,
   input  wire logic [31:0] dl_word_i,
   // word toward display list memory
   output logic             dl_valid_o,
   output logic [31:0]      dl_word_o
);
   // ****************************************************************
   // substitution stage, one cycle of latency
   // ****************************************************************
   logic        valid_ff; // word ready for display list memory
   logic [31:0] word_ff;  // word after substitution
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         valid_ff <= 1'b0;
         word_ff  <= 32'h0000_0000;
      end else begin
         valid_ff <= dl_valid_i;
         if (dl_valid_i) begin
            if (dl_word_i[31:24] != mcrb_pkg::MACRO_OPC) begin
               word_ff <= dl_word_i;           // ordinary command
            end else if (dl_word_i[0]) begin
               word_ff <= cfg.macro_one;       // R8
            end else begin
               word_ff <= cfg.macro_zero;      // R9
            end
         end
      end
   end
   assign dl_valid_o = valid_ff;
   assign dl_word_o  = word_ff;
endmodule : mcrb_macro

// *** mcrb_top.sv ***
// mcrb_top: miscellaneous control register bank of the display
// controller, reached over an avalon-mm slave with waitrequest.
// assumes: one clock, synchronous reset; engines, command fifo and
// interrupt sources are logic on the same clock.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
// How it works
// R1: bulk port word goes to command fifo
// R2: host bursts no more than free bytes
// R3: host writes bulk port in whole words
// R4: 12-bit free byte count, resets to 0xffc
// R5: reset bits: audio 2, touch 1, coprocessor 0
// R6: writing one holds engine, zero releases
// R7: reading bit shows engine reset state
// R8: macro parameter one substitutes macro-one value
// R9: macro parameter zero substitutes macro-zero value
// R10: duty 0..128, off to fully on
// R11: frequency 14 bits, default 250 hz
// R12: mask bit one enables its source
// R13: free space drops four per word, never overfilled
module mcrb_top (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // avalon-mm slave
   input  wire logic [11:0] avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   // command fifo of the coprocessor
   output logic             cmd_valid_o,
   output logic [31:0]      cmd_data_o,
   input  wire logic        cmd_consumed_i,
   // engine resets
   output logic             audio_rst_o,
   output logic             touch_rst_o,
   output logic             copro_rst_o,
   // display list stream
   input  wire logic        dl_valid_i,
   input  wire logic [31:0] dl_word_i,
   output logic             dl_valid_o,
   output logic [31:0]      dl_word_o,
   // backlight
   output logic             backlight_o,
   // interrupts
   input  wire logic [7:0]  int_src_i,
   output logic             irq_o
);
   // ****************************************************************
   // helpers
   // ****************************************************************
   // merge write data into a register under the byte enables
   function automatic logic [31:0] be_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  be
   );
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // true when the bus addresses a given register
   function automatic logic hit(
      input logic [11:0] addr,
      input logic [11:0] ofs
   );
      return {addr[11:2], 2'b00} == ofs;
   endfunction : hit

   // ****************************************************************
   // state
   // ****************************************************************
   logic [mcrb_pkg::ENG_W-1:0]  engine_reset_ff;  // engines held in reset
   logic [mcrb_pkg::INT_W-1:0]  int_mask_ff;      // interrupt source mask
   logic [mcrb_pkg::INT_W-1:0]  int_status_ff;    // sticky source events
   logic [mcrb_pkg::HZ_W-1:0]   pwm_hz_ff;        // backlight frequency
   logic [mcrb_pkg::DUTY_W-1:0] pwm_duty_ff;      // backlight duty
   logic [31:0]                 macro_zero_ff;    // macro 0 value
   logic [31:0]                 macro_one_ff;     // macro 1 value
   logic [mcrb_pkg::FREE_W-1:0] free_bytes_ff;    // command fifo free bytes
   logic [mcrb_pkg::FREE_W-1:0] nxt_free_bytes;   // next free byte count
   logic                        cmd_valid_ff;     // word pushed this cycle
   logic [31:0]                 cmd_data_ff;      // word toward the fifo
   logic                        rd_done_ff;       // read data now valid
   logic [31:0]                 rdata_ff;         // captured read data
   logic [31:0]                 nxt_rdata;        // read data mux
   logic                        wr_reg;           // write taken this cycle
   logic                        bulk_hit;         // bulk port addressed
   logic                        bulk_push;        // bulk word accepted
   logic                        room;             // a whole word fits
   logic [mcrb_pkg::INT_W-1:0]  status_clr;       // write-one-to-clear
   logic [31:0]                 hz_merged;        // hz word after merge

   // ****************************************************************
   // bus handshake
   // ****************************************************************
   // a bulk write stalls while no whole word of space is left, so the
   // host can never overfill the fifo even if it ignores the count
   assign bulk_hit  = hit(avs_address_i, mcrb_pkg::OFS_BULK_WRITE);
   assign room      = free_bytes_ff >= mcrb_pkg::WORD_BYTES;
   assign bulk_push = avs_write_i & bulk_hit & room; // R13
   // plain writes finish at once; bulk writes wait for room
   assign wr_reg    = avs_write_i & ~bulk_hit;

   // reads take two cycles so the data comes from a flip-flop
   // a read held past its answer starts a second access
   always_comb begin
      if (avs_read_i) begin
         avs_waitrequest_o = ~rd_done_ff;
      end else if (avs_write_i && bulk_hit) begin
         avs_waitrequest_o = ~room;
      end else begin
         avs_waitrequest_o = 1'b0;
      end
   end

   // read phase marker, high for one cycle and then cleared whether or not the master releases
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rd_done_ff <= 1'b0;
      end else begin
         rd_done_ff <= avs_read_i & ~rd_done_ff;
      end
   end

   // ****************************************************************
   // read data
   // ****************************************************************
   // unmapped and write-only addresses read as zero
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      case ({avs_address_i[11:2], 2'b00})
         mcrb_pkg::OFS_ENGINE_RESET: begin
            nxt_rdata[mcrb_pkg::ENG_W-1:0] = engine_reset_ff; // R7
         end
         mcrb_pkg::OFS_INT_MASK: begin
            nxt_rdata[mcrb_pkg::INT_W-1:0] = int_mask_ff;
         end
         mcrb_pkg::OFS_INT_STATUS: begin
            nxt_rdata[mcrb_pkg::INT_W-1:0] = int_status_ff;
         end
         mcrb_pkg::OFS_PWM_HZ: begin
            nxt_rdata[mcrb_pkg::HZ_W-1:0] = pwm_hz_ff;
         end
         mcrb_pkg::OFS_PWM_DUTY: begin
            nxt_rdata[mcrb_pkg::DUTY_W-1:0] = pwm_duty_ff;
         end
         mcrb_pkg::OFS_MACRO_ZERO: begin
            nxt_rdata = macro_zero_ff;
         end
         mcrb_pkg::OFS_MACRO_ONE: begin
            nxt_rdata = macro_one_ff;
         end
         mcrb_pkg::OFS_FREE_BYTES: begin
            nxt_rdata[mcrb_pkg::FREE_W-1:0] = free_bytes_ff; // R4
         end
         default: begin
            nxt_rdata = 32'h0000_0000;
         end
      endcase
   end

   // capture in the first read cycle, hold while the master looks
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_read_i && !rd_done_ff) begin
         rdata_ff <= nxt_rdata;
      end
   end
   assign avs_readdata_o = rdata_ff;

   // ****************************************************************
   // engine reset control
   // ****************************************************************
   // one holds an engine in reset until software writes zero
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         engine_reset_ff <= mcrb_pkg::RST_ENGINE; // R5
      end else if (wr_reg &&
                   hit(avs_address_i, mcrb_pkg::OFS_ENGINE_RESET) &&
                   avs_byteenable_i[0]) begin
         engine_reset_ff <= avs_writedata_i[mcrb_pkg::ENG_W-1:0]; // R6
      end
   end
   assign audio_rst_o = engine_reset_ff[mcrb_pkg::ENG_AUDIO_BIT]; // R5
   assign touch_rst_o = engine_reset_ff[mcrb_pkg::ENG_TOUCH_BIT]; // R5
   assign copro_rst_o = engine_reset_ff[mcrb_pkg::ENG_COPRO_BIT]; // R5

   // ****************************************************************
   // backlight and macro settings
   // ****************************************************************
   // values are stored as written; the pwm clamps out-of-range ones
   // merged as a full word first, then cut back to the 14-bit field
   assign hz_merged = be_merge(32'(pwm_hz_ff), avs_writedata_i,
                               avs_byteenable_i);
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pwm_hz_ff <= mcrb_pkg::RST_HZ; // R11
      end else if (wr_reg && hit(avs_address_i, mcrb_pkg::OFS_PWM_HZ)) begin
         pwm_hz_ff <= hz_merged[mcrb_pkg::HZ_W-1:0]; // R11
      end
   end

   // duty register
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pwm_duty_ff <= mcrb_pkg::RST_DUTY;
      end else if (wr_reg &&
                   hit(avs_address_i, mcrb_pkg::OFS_PWM_DUTY) &&
                   avs_byteenable_i[0]) begin
         pwm_duty_ff <= avs_writedata_i[mcrb_pkg::DUTY_W-1:0]; // R10
      end
   end

   // macro substitute values
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         macro_zero_ff <= mcrb_pkg::RST_MACRO;
         macro_one_ff  <= mcrb_pkg::RST_MACRO;
      end else if (wr_reg) begin
         if (hit(avs_address_i, mcrb_pkg::OFS_MACRO_ZERO)) begin
            macro_zero_ff <= be_merge(macro_zero_ff, avs_writedata_i,
                                      avs_byteenable_i);
         end
         if (hit(avs_address_i, mcrb_pkg::OFS_MACRO_ONE)) begin
            macro_one_ff <= be_merge(macro_one_ff, avs_writedata_i,
                                     avs_byteenable_i);
         end
      end
   end

   // ****************************************************************
   // bulk command port and free space
   // ****************************************************************
   // byte enables are not checked: the host owes whole words
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cmd_valid_ff <= 1'b0;
         cmd_data_ff  <= 32'h0000_0000;
      end else begin
         cmd_valid_ff <= bulk_push; // R1
         if (bulk_push) begin
            cmd_data_ff <= avs_writedata_i; // R1 R3
         end
      end
   end
   assign cmd_valid_o = cmd_valid_ff;
   assign cmd_data_o  = cmd_data_ff;

   // free space falls per push, rises per consumed word; a held
   // coprocessor reset empties the fifo view back to full space
   always_comb begin
      nxt_free_bytes = free_bytes_ff;
      if (bulk_push) begin
         nxt_free_bytes = nxt_free_bytes - mcrb_pkg::WORD_BYTES; // R13
      end
      if (cmd_consumed_i && nxt_free_bytes < mcrb_pkg::RST_FREE) begin
         nxt_free_bytes = nxt_free_bytes + mcrb_pkg::WORD_BYTES;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         free_bytes_ff <= mcrb_pkg::RST_FREE; // R4
      end else if (engine_reset_ff[mcrb_pkg::ENG_COPRO_BIT]) begin
         free_bytes_ff <= mcrb_pkg::RST_FREE;
      end else begin
         free_bytes_ff <= nxt_free_bytes; // R4 R13
      end
   end

   // ****************************************************************
   // interrupts
   // ****************************************************************
   // mask register: one lets a source through
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         int_mask_ff <= mcrb_pkg::RST_MASK;
      end else if (wr_reg &&
                   hit(avs_address_i, mcrb_pkg::OFS_INT_MASK) &&
                   avs_byteenable_i[0]) begin
         int_mask_ff <= avs_writedata_i[mcrb_pkg::INT_W-1:0]; // R12
      end
   end

   // writing one clears a status bit
   assign status_clr = (wr_reg &&
                        hit(avs_address_i, mcrb_pkg::OFS_INT_STATUS) &&
                        avs_byteenable_i[0]) ?
                       avs_writedata_i[mcrb_pkg::INT_W-1:0] : 8'h00;

   // a new event in the clearing cycle wins, so none is lost
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         int_status_ff <= 8'h00;
      end else begin
         int_status_ff <= (int_status_ff & ~status_clr) | int_src_i;
      end
   end

   // level output while any enabled event is pending
   // the mask gates only the output; status still records events
   assign irq_o = |(int_status_ff & int_mask_ff); // R12

   // ****************************************************************
   // helpers: backlight pwm and macro substitution
   // ****************************************************************
   mcrb_cfg_if cfg_if ();
   assign cfg_if.pwm_hz     = pwm_hz_ff;
   assign cfg_if.pwm_duty   = pwm_duty_ff;
   assign cfg_if.macro_zero = macro_zero_ff;
   assign cfg_if.macro_one  = macro_one_ff;

   mcrb_pwm #(
      .ACC_W       (32)
   ) u_pwm (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .cfg         (cfg_if.pwm_sink),
      .backlight_o (backlight_o)
   );

   mcrb_macro u_macro (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .cfg         (cfg_if.macro_sink),
      .dl_valid_i  (dl_valid_i),
      .dl_word_i   (dl_word_i),
      .dl_valid_o  (dl_valid_o),
      .dl_word_o   (dl_word_o)
   );
endmodule : mcrb_top

// *** mcrb_top_assertions.sv ***
// mcrb_top_assertions: port-level checks of the register bank.
// assumes: bound to mcrb_top, one clock, synchronous reset.
`timescale 1ns/10ps
module mcrb_top_assertions (
   // clock and reset
   input logic        mclk_i,
   input logic        rst_i,
   // register bus
   input logic [11:0] avs_address_i,
   input logic        avs_read_i,
   input logic        avs_write_i,
   input logic [31:0] avs_writedata_i,
   input logic [3:0]  avs_byteenable_i,
   input logic [31:0] avs_readdata_o,
   input logic        avs_waitrequest_o,
   // command push and engine resets
   input logic        cmd_valid_o,
   input logic [31:0] cmd_data_o,
   input logic        audio_rst_o,
   input logic        touch_rst_o,
   input logic        copro_rst_o,
   // display list and interrupt
   input logic        dl_valid_i,
   input logic [31:0] dl_word_i,
   input logic        dl_valid_o,
   input logic [31:0] dl_word_o,
   input logic        irq_o
);
   // ****************************************************************
   // decodes and checks
   // ****************************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   wire       acc  = !avs_waitrequest_o;             // access ends
   wire       bulk = avs_address_i[11:2] == 10'h15e; // bulk port
   wire       eng  = avs_address_i[11:2] == 10'h008; // engine resets
   wire [2:0] engs = {audio_rst_o, touch_rst_o, copro_rst_o};
   chk_bulk_push: assert property (
      avs_write_i && bulk && acc |=>
      cmd_valid_o && cmd_data_o == $past(avs_writedata_i))
      else $error("bulk word not pushed");
   chk_push_cause: assert property (
      cmd_valid_o |-> $past(avs_write_i && bulk && acc))
      else $error("push without accepted word");
   chk_eng_write: assert property (
      avs_write_i && eng && acc && avs_byteenable_i[0] |=>
      engs == $past(avs_writedata_i[2:0]))
      else $error("engine reset bits wrong");
   chk_eng_hold: assert property (
      !(avs_write_i && eng) |=> $stable(engs))
      else $error("engine reset moved alone");
   chk_eng_read: assert property (
      avs_read_i && eng && acc |-> avs_readdata_o == {29'h0, engs})
      else $error("engine reset readback wrong");
   chk_read_wait: assert property (
      $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("read wait state wrong");
   chk_free_width: assert property (
      avs_read_i && avs_address_i[11:2] == 10'h15d && acc |->
      avs_readdata_o[31:12] == 20'h0)
      else $error("free count too wide");
   chk_dl_pass: assert property (
      dl_valid_i && dl_word_i[31:24] != 8'h25 |=>
      dl_valid_o && dl_word_o == $past(dl_word_i))
      else $error("plain display word altered");
   // main scenarios reached
   cov_stall: cover property (avs_write_i && bulk && avs_waitrequest_o);
   cov_macro: cover property (dl_valid_i && dl_word_i[31:24] == 8'h25);
   cov_irq:   cover property (irq_o);
endmodule : mcrb_top_assertions
bind mcrb_top mcrb_top_assertions u_chk (.*);

// *** mcrb_copro_model.sv ***
// mcrb_copro_model: coprocessor side that fetches pushed command words.
// assumes: same clock as the bank; drain_i lets it stall or run.
`timescale 1ns/10ps
module mcrb_copro_model (
   input  wire logic mclk_i,
   input  wire logic rst_i,
   input  wire logic cmd_valid_i,
   input  wire logic drain_i,
   output logic      cmd_consumed_o = 1'b0
);
   int   pend = 0; // words pushed, not yet fetched
   logic take;     // fetch one word now
   // every other cycle at most, so the free count climbs in steps
   assign take = drain_i && pend != 0 && !cmd_consumed_o;
   always @(posedge mclk_i) begin
      if (rst_i) begin
         pend <= 0;
         cmd_consumed_o <= 1'b0;
      end else begin
         pend <= pend + int'(cmd_valid_i) - int'(take);
         cmd_consumed_o <= take;
      end
   end
endmodule : mcrb_copro_model

// *** misc_control_register_bank_bench.sv ***
// bench: random and corner traffic through the avalon-mm slave.
// assumes: copro model fetches words only while drain is set.
`timescale 1ns/10ps
module misc_control_register_bank_bench;
   logic        mclk_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0;
   logic        cmd_consumed_i, dl_valid_i = 0, drain = 0;
   logic        cmd_valid_o, avs_waitrequest_o, dl_valid_o, irq_o;
   logic        audio_rst_o, touch_rst_o, copro_rst_o, backlight_o;
   logic [11:0] avs_address_i = 0;
   logic [31:0] avs_writedata_i = 0, dl_word_i = 0, q, w, m0, m1;
   logic [31:0] avs_readdata_o, cmd_data_o, dl_word_o;
   logic [3:0]  avs_byteenable_i = 4'hf;
   logic [7:0]  int_src_i = 0, b;
   int          err_total = 0, tests_run = 0, cyc = 0, c0;
   // reset values, then unmapped and write-only places reading zero
   logic [11:0] ofs [9] = '{12'h020, 12'h0b0, 12'h0d0, 12'h0d4, 12'h0d8,
                           12'h0dc, 12'h574, 12'h578, 12'h300};
   logic [31:0] rv [9] = '{0, 32'hff, 32'hfa, 32'h80, 0, 0, 32'hffc, 0, 0};
   mcrb_top dut (.*);
   mcrb_copro_model u_copro (.mclk_i, .rst_i, .cmd_valid_i(cmd_valid_o),
      .drain_i(drain), .cmd_consumed_o(cmd_consumed_i));
   initial forever #4 mclk_i = ~mclk_i;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("BAD t=%0t seen %h want %h", $time, s, e);
      end
   endtask : chk
   // one access; held until waitrequest is low at a rising edge
   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      avs_writedata_i <= d;
      do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : bus
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd
   task automatic dl(input logic [31:0] x, input logic [31:0] e);
      @(posedge mclk_i);
      dl_valid_i <= 1'b1;
      dl_word_i <= x;
      @(posedge mclk_i);
      dl_valid_i <= 1'b0;
      @(negedge mclk_i);
      chk(dl_word_o, e);
   endtask : dl
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // hang guard, far above the cycles needed
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   initial begin
      void'($urandom(54));
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 9; i++) rd(ofs[i], rv[i]);
      // engine resets, reserved bits written with noise
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 12'h020, 32'(i) | ($urandom & 32'hffff_fff8));
         rd(12'h020, 32'(i));
         chk({audio_rst_o, touch_rst_o, copro_rst_o}, 32'(i));
      end
      bus(1'b1, 12'h020, 32'h0);
      m0 = $urandom;
      m1 = $urandom;
      bus(1'b1, 12'h0d8, m0);
      bus(1'b1, 12'h0dc, m1);
      dl(32'h2500_0001, m1);
      dl(32'h2500_0000, m0);
      dl(32'h1200_0001, 32'h1200_0001);
      // fill whole words up to the free count, never beyond
      for (int i = 0; i < 1023; i++) begin
         w = $urandom;
         bus(1'b1, 12'h578, w);
         if (i < 2) rd(12'h574, 32'hff8 - 32'(4 * i));
      end
      rd(12'h574, 32'h0);
      chk(cmd_data_o, w);
      c0 = cyc;
      w = $urandom;
      // full: the next word stalls until a fetch
      fork
         bus(1'b1, 12'h578, w);
         begin
            repeat (30) @(posedge mclk_i);
            drain <= 1'b1;
         end
      join
      chk(32'(cyc - c0 > 30), 32'h1);
      repeat (2100) @(posedge mclk_i);
      rd(12'h574, 32'hffc);
      chk(cmd_data_o, w);
      // interrupt: masked event hides, unmasked shows, clear drops
      b = 8'h1 << ($urandom % 8);
      bus(1'b1, 12'h0b0, 32'h0);
      @(posedge mclk_i);
      int_src_i <= b;
      @(posedge mclk_i);
      int_src_i <= 8'h0;
      @(negedge mclk_i);
      chk(irq_o, 32'h0);
      bus(1'b1, 12'h0b0, {24'h0, b});
      rd(12'h580, {24'h0, b});
      chk(irq_o, 32'h1);
      bus(1'b1, 12'h580, {24'h0, b});
      rd(12'h580, 32'h0);
      chk(irq_o, 32'h0);
      // backlight extremes at the top frequency
      bus(1'b1, 12'h0d0, 32'd10000);
      rd(12'h0d0, 32'h2710);
      for (int d = 0; d < 2; d++) begin
         bus(1'b1, 12'h0d4, 32'(d * 128));
         repeat (2) @(posedge mclk_i);
         repeat (300) @(negedge mclk_i) chk(backlight_o, 32'(d));
      end
      tally_and_finish();
   end
endmodule : misc_control_register_bank_bench
